// ===== shared/clock_source_pkg.sv
package clock_source_pkg;

   // Clock mode field encoding (fixed mapping, see hand-over)
   typedef enum logic [2:0] {
      MODE_LP     = 3'h0,
      MODE_XT     = 3'h1,
      MODE_HS     = 3'h2,
      MODE_EC     = 3'h3,
      MODE_INTIO  = 3'h4,
      MODE_INTCLK = 3'h5,
      MODE_RC_PINS_FREE_MODE   = 3'h6,
      MODE_RC     = 3'h7
   } clock_mode_t;

   // Start-up state machine, Gray coded along powerup->count->run
   typedef enum logic [1:0] {
      ST_POWERUP = 2'h0,
      ST_COUNT   = 2'h1,
      ST_RUN     = 2'h3
   } startup_state_t;

   // APB byte addresses
   localparam logic [7:0] OSC_CONTROL_ADDR   = 8'h00;
   localparam logic [7:0] OSC_FREQ_TRIM_ADDR = 8'h04;
   localparam logic [7:0] CLOCK_STATUS_ADDR  = 8'h08;

   // Field positions
   localparam int FREQ_SEL_LSB = 4;
   localparam int LOCKED_BIT   = 3;
   localparam int STABLE_BIT   = 2;

   // Reset values
   localparam logic [1:0] FREQ_SEL_RESET = 2'h2;
   localparam logic [5:0] TRIM_RESET     = 6'h00;

   // Oscillations counted before leaving reset
   localparam int STARTUP_OSC_COUNT = 1024;

   // Clock and internal source timing
   localparam int CLK_FREQ_KHZ = 50000;
   localparam int SLOW_SRC_KHZ = 500;
   localparam int FAST_SRC_KHZ = 16000;
   // Postscaled source dividers from the 50 MHz clock
   localparam int SLOW_SRC_DIV = CLK_FREQ_KHZ / SLOW_SRC_KHZ;
   localparam int FAST_SRC_DIV = 3;

   // Settle times of the internal source after a trim change, in microseconds
   localparam int LOCK_TIME_US   = 20;
   localparam int STABLE_TIME_US = 100;
   localparam int LOCK_CYCLES    = LOCK_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int STABLE_CYCLES  = STABLE_TIME_US * CLK_FREQ_KHZ / 1000;

endpackage

// ===== core/clock_source_select.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module clock_source_select #(
   parameter int STARTUP_COUNT = clock_source_pkg::STARTUP_OSC_COUNT,
   parameter int STABLE_WAIT   = clock_source_pkg::STABLE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,

   // Programmed configuration
   input  wire logic [2:0]  clockModeSel,
   input  wire logic        fastSourceEnable,

   // Start-up control
   input  wire logic        powerUpDelayDone,
   input  wire logic        wakeFromSleep,
   input  wire logic        systemClockRun,

   // Clock pins
   input  wire logic        primaryClockPin,
   output logic             primaryPinFree,
   output logic             secondaryPinOut,
   output logic             secondaryPinOe,
   output logic             secondaryPinFree,

   // Derived clocking
   output logic             intClockEn,
   output logic             holdInReset,
   output logic [5:0]       freqTrimValue
);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode

   clock_source_pkg::clock_mode_t mode;
   assign mode = clock_source_pkg::clock_mode_t'(clockModeSel);

   wire isCrystal = (mode == clock_source_pkg::MODE_LP) ||
                    (mode == clock_source_pkg::MODE_XT) ||
                    (mode == clock_source_pkg::MODE_HS);
   wire isInternal = (mode == clock_source_pkg::MODE_INTIO) ||
                     (mode == clock_source_pkg::MODE_INTCLK);
   wire clkOutRc  = (mode == clock_source_pkg::MODE_RC);
   wire clkOutInt = (mode == clock_source_pkg::MODE_INTCLK);

   // Modes that hand the secondary pin back to general I/O
   wire rcPinsFree  = (mode == clock_source_pkg::MODE_RC_PINS_FREE_MODE);
   wire extClock    = (mode == clock_source_pkg::MODE_EC);
   wire intPinsFree = (mode == clock_source_pkg::MODE_INTIO);

   ////////////////////////////////////////////////////////////////////////////
   // Primary pin synchroniser and edge detect

   logic pinSync1_q;
   logic pinSync2_q;
   logic pinLast_q;

   // Pin is asynchronous to clk; only the second stage is read
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
      end else begin
         pinSync1_q <= primaryClockPin;
         pinSync2_q <= pinSync1_q;
      end
   end

   // Cleared to the idle low level so no false edge follows reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinLast_q <= 1'b0;
      end else begin
         pinLast_q <= pinSync2_q;
      end
   end

   wire pinRise = pinSync2_q && !pinLast_q;

   ////////////////////////////////////////////////////////////////////////////
   // Start-up counter

   clock_source_pkg::startup_state_t state_q;
   clock_source_pkg::startup_state_t state_d;
   logic [10:0] oscCount_q;
   logic [10:0] oscCount_d;

   wire countDone   = (oscCount_q == 11'(STARTUP_COUNT - 1)) && pinRise;
   wire wakeRestart = wakeFromSleep && isCrystal;

   // Crystal waits for oscillations, others start at once
   clock_source_pkg::startup_state_t firstState;
   assign firstState = isCrystal ? clock_source_pkg::ST_COUNT
                                 : clock_source_pkg::ST_RUN;

   always_comb begin
      state_d    = state_q;
      oscCount_d = oscCount_q;
      case (state_q)
         clock_source_pkg::ST_POWERUP: begin
            oscCount_d = 11'h000;
            if (powerUpDelayDone) begin
               state_d = firstState;
            end
         end

         clock_source_pkg::ST_COUNT: begin
            if (pinRise) begin
               oscCount_d = oscCount_q + 11'h001;
            end
            if (countDone) begin
               state_d = clock_source_pkg::ST_RUN;
            end
         end

         clock_source_pkg::ST_RUN: begin
            oscCount_d = 11'h000;
            if (wakeRestart) begin
               state_d = clock_source_pkg::ST_COUNT;
            end
         end

         default: begin
            state_d    = clock_source_pkg::ST_POWERUP;
            oscCount_d = 11'h000;
         end
      endcase
   end

   // Frozen while the system clock is stopped so nothing is lost
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q    <= clock_source_pkg::ST_POWERUP;
         oscCount_q <= 11'h000;
      end else if (systemClockRun) begin
         state_q    <= state_d;
         oscCount_q <= oscCount_d;
      end
   end

   assign holdInReset = (state_q != clock_source_pkg::ST_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [1:0] freqSel_q;
   logic [5:0] trim_q;
   logic       fastSrc_q;

   wire       accessPhase  = psel && penable;
   wire       setupPhase   = psel && !penable;
   wire       writeEn      = accessPhase && pwrite;
   wire       hitControl   = (paddr == clock_source_pkg::OSC_CONTROL_ADDR);
   wire       hitTrim      = (paddr == clock_source_pkg::OSC_FREQ_TRIM_ADDR);
   wire       hitStatus    = (paddr == clock_source_pkg::CLOCK_STATUS_ADDR);
   wire       mapped       = hitControl || hitTrim || hitStatus;
   wire       controlWrite = writeEn && hitControl;
   wire       trimWrite    = writeEn && hitTrim;
   wire [1:0] freqSelIn    = pwdata[clock_source_pkg::FREQ_SEL_LSB +: 2];
   wire [5:0] trimIn       = pwdata[5:0];

   // No settling: the postscaler follows the new code at its next tick
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         freqSel_q <= clock_source_pkg::FREQ_SEL_RESET;
      end else if (controlWrite) begin
         freqSel_q <= freqSelIn;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         trim_q <= clock_source_pkg::TRIM_RESET;
      end else if (trimWrite) begin
         trim_q <= trimIn;
      end
   end

   // Followed only while held in reset, so software can never move it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fastSrc_q <= 1'b0;
      end else if (holdInReset) begin
         fastSrc_q <= fastSourceEnable;
      end
   end

   assign freqTrimValue = trim_q;

   ////////////////////////////////////////////////////////////////////////////
   // Lock and stability tracking; a trim write restarts settling

   logic [15:0] settle_q;

   wire settleClear = !rst_b || trimWrite;
   wire settleFull  = (settle_q == 16'(STABLE_WAIT));

   // Saturates so the flags never wrap back to unlocked
   always_ff @(posedge clk) begin
      if (settleClear) begin
         settle_q <= 16'h0000;
      end else if (!settleFull) begin
         settle_q <= settle_q + 16'h0001;
      end
   end

   wire locked = (settle_q >= 16'(clock_source_pkg::LOCK_CYCLES));
   wire stable = settleFull;

   ////////////////////////////////////////////////////////////////////////////
   // Internal source and postscaler

   logic [6:0] srcDiv_q;
   logic [2:0] post_q;
   logic [1:0] quarter_q;
   logic       clkOut_q;

   wire [6:0] srcLimit = fastSrc_q ? 7'(clock_source_pkg::FAST_SRC_DIV - 1)
                                   : 7'(clock_source_pkg::SLOW_SRC_DIV - 1);
   wire srcTick = (srcDiv_q == srcLimit);

   // Code 11 divides by 1, 00 by 8
   function automatic logic postHit(input logic [1:0] sel, input logic [2:0] cnt);
      case (sel)
         2'h3:    postHit = 1'b1;
         2'h2:    postHit = cnt[0];
         2'h1:    postHit = &cnt[1:0];
         default: postHit = &cnt;
      endcase
   endfunction

   assign intClockEn = srcTick && postHit(freqSel_q, post_q);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         srcDiv_q <= 7'h00;
         post_q   <= 3'h0;
      end else begin
         srcDiv_q <= srcTick ? 7'h00 : srcDiv_q + 7'h01;
         if (srcTick) begin
            post_q <= post_q + 3'h1;
         end
      end
   end

   // One step per system clock tick of the selected mode
   wire quarterStep = (clkOutInt && intClockEn) || (clkOutRc && pinRise);

   // Toggle every two system ticks gives a divide by four
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         quarter_q <= 2'h0;
         clkOut_q  <= 1'b0;
      end else if (quarterStep) begin
         quarter_q <= quarter_q + 2'h1;
         if (quarter_q[0]) begin
            clkOut_q <= !clkOut_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin ownership

   assign secondaryPinOe   = clkOutRc || clkOutInt;
   assign secondaryPinOut  = secondaryPinOe && clkOut_q;
   assign secondaryPinFree = rcPinsFree || extClock || intPinsFree;
   assign primaryPinFree   = isInternal;

   ////////////////////////////////////////////////////////////////////////////
   // APB read

   wire [7:0]  controlRead = {2'h0, freqSel_q, locked, stable, 2'h0};
   wire [31:0] controlWord = {24'h000000, controlRead};
   wire [31:0] trimWord    = {26'h0, trim_q};
   wire [31:0] statusWord  = {26'h0, fastSrc_q, holdInReset, clockModeSel, isCrystal};
   wire [31:0] readWord    = hitControl ? controlWord :
                             hitTrim    ? trimWord    :
                             hitStatus  ? statusWord  :
                                          32'h00000000;
   wire        readSetup   = setupPhase && !pwrite;

   // Zero wait states: every access ends in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = accessPhase && !mapped;

   // Loaded in the setup cycle so the word stands at the access edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (readSetup) begin
         prdata <= readWord;
      end
   end

endmodule // clock_source_select

`default_nettype wire

// ===== dv/crystal_model.sv
`timescale 1ns/1ps
`default_nettype none
module crystal_model #(
   parameter realtime HALF_PERIOD = 50.0
) (
   input  wire logic run,
   output wire logic pin
);
   logic level = 1'b0;
   assign pin = level;
   // Logic-level swing; stands still low when stopped so no stray edge is counted
   always begin
      if (run) begin
         #(HALF_PERIOD) level = ~level;
      end else begin
         level = 1'b0;
         wait (run);
      end
   end
endmodule // crystal_model
`default_nettype wire

// ===== dv/clock_source_props.sv
`timescale 1ns/1ps
`default_nettype none
module clock_source_props (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [2:0]  clockModeSel,
   input wire logic        powerUpDelayDone,
   input wire logic        systemClockRun,
   input wire logic        primaryPinFree,
   input wire logic        secondaryPinOe,
   input wire logic        secondaryPinFree,
   input wire logic        intClockEn,
   input wire logic        holdInReset,
   input wire logic [5:0]  freqTrimValue
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic       acc;
   logic [2:0] m;
   assign acc = psel && penable;
   assign m   = clockModeSel;
   ////////////////////////////////////////////////////////////////////////////////
   unmapped_err_a: assert property (acc |-> pslverr == (paddr != 8'h00 && paddr != 8'h04
      && paddr != 8'h08)) else $error("pslverr wrong for address");
   ctrl_zero_a: assert property (acc && !pwrite && paddr == 8'h00 |->
      prdata[31:6] == 26'h0 && prdata[1:0] == 2'h0) else $error("control spare bits set");
   trim_store_a: assert property (acc && pwrite && paddr == 8'h04 |=>
      freqTrimValue == $past(pwdata[5:0])) else $error("trim not stored");
   sec_drive_a: assert property (secondaryPinOe == (m == 3'h5 || m == 3'h7))
      else $error("secondary drive wrong for mode");
   prim_free_a: assert property (primaryPinFree == (m == 3'h4 || m == 3'h5))
      else $error("primary pin release wrong");
   sec_free_a: assert property (secondaryPinFree == (m == 3'h3 || m == 3'h4 || m == 3'h6))
      else $error("secondary pin release wrong");
   ec_release_a: assert property (holdInReset && powerUpDelayDone && systemClockRun
      && m == 3'h3 |=> !holdInReset) else $error("external clock mode delayed");
   delay_hold_a: assert property (holdInReset && !powerUpDelayDone |=> holdInReset)
      else $error("left reset before delay timer");
   static_halt_a: assert property (!systemClockRun |=> $stable(holdInReset))
      else $error("start-up moved while halted");
   pulse_single_a: assert property (intClockEn |=> !intClockEn)
      else $error("internal enable wider than one cycle");
endmodule // clock_source_props
bind clock_source_select clock_source_props chk (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .clockModeSel(clockModeSel), .powerUpDelayDone(powerUpDelayDone),
   .systemClockRun(systemClockRun), .primaryPinFree(primaryPinFree),
   .secondaryPinOe(secondaryPinOe), .secondaryPinFree(secondaryPinFree),
   .intClockEn(intClockEn), .holdInReset(holdInReset), .freqTrimValue(freqTrimValue));
`default_nettype wire

// ===== dv/clock_source_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_source_select_bench;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, fast, done, wake, run;
   logic        xtal, pin, pFree, sOut, sOe, sFree, intEn, hold;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic [2:0]  mode;
   logic [32:0] expQ[$];
   int          failCount, samplesChecked, seed, n, w, e;
   localparam logic [7:0] CA = clock_source_pkg::OSC_CONTROL_ADDR;
   localparam logic [7:0] TA = clock_source_pkg::OSC_FREQ_TRIM_ADDR;
   clock_source_select #(.STARTUP_COUNT(8), .STABLE_WAIT(1000)) uut (.clk(clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .clockModeSel(mode),
      .fastSourceEnable(fast), .powerUpDelayDone(done), .wakeFromSleep(wake),
      .systemClockRun(run), .primaryClockPin(pin), .primaryPinFree(pFree),
      .secondaryPinOut(sOut), .secondaryPinOe(sOe), .secondaryPinFree(sFree),
      .intClockEn(intEn), .holdInReset(hold), .freqTrimValue());
   crystal_model xo (.run(xtal), .pin(pin));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic completeRun();
      if (failCount == 0 && samplesChecked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [32:0] ctrl(input logic [1:0] sel, input logic st);
      return {27'h0, sel, st, st, 2'h0};
   endfunction
   // Ends one idle cycle after release, so back-to-back calls never double-drive psel
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat,
                      input logic [32:0] ex);
      if (!wr) expQ.push_back(ex);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= dat;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, expQ.pop_front());
   end
   task automatic doReset();
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask
   task automatic waitHold(input logic v);
      n = 0;
      while (hold !== v && n < 300) begin
         @(negedge clk);
         n++;
      end
      cmp(33'(hold), 33'(v));
      @(posedge clk);
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      failCount++;
      completeRun();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_b, psel, penable, pwrite, wake, fast, done} = 7'h00;
      {run, xtal, paddr, pwdata, mode, seed} = {2'h3, 40'h0, 3'h2, 32'd88};
      {failCount, samplesChecked} = {32'h0, 32'h0};
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (50) @(posedge clk);
      cmp(33'(hold), 33'h1);
      xtal <= 1'b0;
      done <= 1'b1;
      repeat (100) @(posedge clk);
      cmp(33'(hold), 33'h1);
      xtal <= 1'b1;
      run  <= 1'b0;
      repeat (100) @(posedge clk);
      cmp(33'(hold), 33'h1);
      run <= 1'b1;
      repeat (10) @(posedge clk);
      cmp(33'(hold), 33'h1);
      waitHold(1'b0);
      wake <= 1'b1;
      xtal <= 1'b0;
      @(posedge clk);
      wake <= 1'b0;
      repeat (50) @(posedge clk);
      cmp(33'(hold), 33'h1);
      xtal <= 1'b1;
      waitHold(1'b0);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         mode <= 3'(k);
         @(negedge clk);
         cmp(33'({pFree, sOe, sFree}), 33'({k == 4 || k == 5, k == 5 || k == 7,
             k == 3 || k == 4 || k == 6}));
      end
      @(posedge clk);
      mode <= clock_source_pkg::MODE_RC;
      n = 0;
      e = 0;
      repeat (400) begin
         @(posedge clk);
         n += int'(sOut && !e[0]);
         e = int'(sOut);
      end
      cmp(33'(n >= 19 && n <= 21), 33'h1);
      mode <= clock_source_pkg::MODE_EC;
      doReset();
      @(negedge clk);
      cmp(33'(hold), 33'h0);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      apb(1'b0, CA, 32'h0, ctrl(2'h2, 1'b0));
      cmp(33'(hold), 33'h0);
      apb(1'b0, TA, 32'h0, 33'h0);
      apb(1'b0, clock_source_pkg::CLOCK_STATUS_ADDR, 32'h0, 33'h06);
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF, 33'h0);
      apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
      repeat (1100) @(posedge clk);
      apb(1'b0, CA, 32'h0, ctrl(2'h2, 1'b1));
      repeat (4) begin
         d = $random(seed);
         apb(1'b1, TA, d, 33'h0);
         apb(1'b0, TA, 32'h0, {27'h0, d[5:0]});
         apb(1'b1, CA, d, 33'h0);
         apb(1'b0, CA, 32'h0, ctrl(d[5:4], 1'b0));
      end
      repeat (1100) @(posedge clk);
      apb(1'b0, CA, 32'h0, ctrl(d[5:4], 1'b1));
      for (int f = 0; f < 2; f++) begin
         fast <= f[0];
         doReset();
         apb(1'b0, CA, 32'h0, ctrl(2'h2, 1'b0));
         w = f ? 240 : 8000;
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, CA, 32'(c << 4), 33'h0);
            n = 0;
            repeat (w) begin
               @(posedge clk);
               n += int'(intEn);
            end
            e = (w / (f ? clock_source_pkg::FAST_SRC_DIV : clock_source_pkg::SLOW_SRC_DIV));
            e = e >> (3 - c);
            cmp(33'(n >= e - 1 && n <= e + 1), 33'h1);
         end
      end
      completeRun();
   end
endmodule // clock_source_select_bench
`default_nettype wire
